// *** shared/scb_pkg.sv ***
// package: special-function register map, field positions and carriers for the sfr bank
package scb_pkg;
   // register addresses
   localparam logic [7:0] SCB_ADDR_LOW         = 8'h80;
   localparam logic [7:0] SCB_ADDR_PORT_ZERO   = 8'h80;
   localparam logic [7:0] SCB_ADDR_STACK_TOP   = 8'h81;
   localparam logic [7:0] SCB_ADDR_DPTR_LOW    = 8'h82;
   localparam logic [7:0] SCB_ADDR_DPTR_HIGH   = 8'h83;
   localparam logic [7:0] SCB_ADDR_POWER       = 8'h87;
   localparam logic [7:0] SCB_ADDR_TIMER_CTL   = 8'h88;
   localparam logic [7:0] SCB_ADDR_PORT_ONE    = 8'h90;
   localparam logic [7:0] SCB_ADDR_CS_CTL_A    = 8'h92;
   // reset values
   localparam logic [7:0] SCB_RST_PORT_ZERO    = 8'hFF;
   localparam logic [7:0] SCB_RST_STACK_TOP    = 8'h07;
   localparam logic [7:0] SCB_RST_DPTR         = 8'h00;
   localparam logic [7:0] SCB_RST_POWER        = 8'h00;
   localparam logic [7:0] SCB_RST_TIMER_CTL    = 8'h00;
   localparam logic [7:0] SCB_RST_CS_CTL_A     = 8'h00;
   localparam logic [7:0] SCB_RST_PORT_ONE     = 8'hFF;
   // power_control bits
   localparam int SCB_PWR_BAUD_DOUBLE  = 7;
   localparam int SCB_PWR_FRAME_ERR_EN = 6;
   localparam int SCB_PWR_USER_ONE     = 3;
   localparam int SCB_PWR_USER_ZERO    = 2;
   localparam int SCB_PWR_POWER_DOWN   = 1;
   localparam int SCB_PWR_SLEEP_CPU    = 0;
   localparam logic [7:0] SCB_PWR_RSVD_MASK = 8'h30;
   // timer_control bits
   localparam int SCB_TC_T1_OVF  = 7;
   localparam int SCB_TC_T1_RUN  = 6;
   localparam int SCB_TC_T0_OVF  = 5;
   localparam int SCB_TC_T0_RUN  = 4;
   localparam int SCB_TC_B_PEND  = 3;
   localparam int SCB_TC_B_TYPE  = 2;
   localparam int SCB_TC_A_PEND  = 1;
   localparam int SCB_TC_A_TYPE  = 0;
   // port-one pin positions for alternate functions
   localparam int SCB_P1_T2_INPUT  = 0;
   localparam int SCB_P1_T2_RELOAD = 1;
   localparam int SCB_P1_ADC_START = 2;

   // special-function bus request from the core
   typedef struct packed {
      logic       rd;       // byte read
      logic       wr;       // byte write
      logic       bit_op;   // single-bit access
      logic       direct;   // direct addressing mode
      logic [7:0] addr;     // byte address, or bit address for bit_op
      logic [7:0] wdata;    // write byte; bit 0 is the bit value
   } scb_req_t;

   // hardware events reaching the bank
   typedef struct packed {
      logic t1_overflow;
      logic t0_overflow;
      logic t1_isr_enter;
      logic t0_isr_enter;
      logic b_isr_enter;
      logic a_isr_enter;
      logic wake;           // enabled interrupt for idle or power-down exit
   } scb_evt_t;

   // control outputs to the rest of the core
   typedef struct packed {
      logic        baud_double;
      logic        frame_error_enable;
      logic        timer_one_run;
      logic        timer_zero_run;
      logic        cpu_clk_en;
      logic        periph_clk_en;
      logic [15:0] data_pointer;
      logic [7:0]  stack_top;
      logic [7:0]  cs_ctl_a;
   } scb_ctl_t;
endpackage

// *** hw/scb_irq_detect.sv ***
// module: external interrupt pin synchroniser and falling-edge or low-level detector
`timescale 1ns/10ps
module scb_irq_detect
(
   input  wire logic clk_i,
   input  wire logic arst_n_i,
   input  wire logic pin_n_i,       // raw active-low pin
   input  wire logic type_edge_i,   // 1 falling edge, 0 low level
   output logic      level_low_o,   // synchronised pin is low
   output logic      fall_o         // one-cycle falling-edge pulse
);
   logic meta_ff;
   logic sync_ff;
   logic prev_ff;

   // two-flop synchroniser; only sync_ff reads meta_ff
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         meta_ff <= 1'b1;
         sync_ff <= 1'b1;
         prev_ff <= 1'b1;
      end
      else
      begin
         meta_ff <= pin_n_i;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   // detection outputs, registered so they come from flops
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         level_low_o <= 1'b0;
         fall_o      <= 1'b0;
      end
      else
      begin
         level_low_o <= ~sync_ff;
         fall_o      <= type_edge_i & prev_ff & ~sync_ff;
      end
   end
endmodule // scb_irq_detect

// *** hw/scb_sfr_bank.sv ***
// module: special-function register bank of the core control group
//
// Overview of operation
// - registers answer only at 80h-FFh and only on direct-addressed accesses
// - addresses ending 0 or 8 also take bit set, clear and test
// - unimplemented addresses and bits read back as one
// - port zero latch is a plain port, but carries address/data on external cycles
// - stack pointer at 81h holds the top-of-stack scratchpad address
// - data pointer is sixteen bits: low byte 82h, high byte 83h
// - power bit 7 doubles serial baud rate in modes 1, 2, 3
// - power bit 6 makes serial control bit 7 a framing error flag
// - power bits 3 and 2 are user flags; bits 5 and 4 reserved
// - power bit 1 enters power-down, stopping all clocks
// - power bit 0 enters idle; peripherals keep running, cpu clock stops
// - timer bit 7 set by timer one overflow, cleared on its isr entry
// - timer bit 5 set by timer zero overflow, cleared on its isr entry
// - timer bits 6 and 4 run timers one and zero
// - timer bits 3 and 1 latch external pins; level mode follows pin
// - timer bits 2 and 0 pick edge or level for pins one and zero
// - port one pin 2 gives rising-edge adc start input
// - port one pins 0 and 1 give timer two input and reload trigger
// - register at 92h holds mode and compare fields for port four pins 0, 1
`timescale 1ns/10ps
module scb_sfr_bank
(
   input  wire logic              clk_i,
   input  wire logic              arst_n_i,
   input  wire scb_pkg::scb_req_t req_i,
   input  wire scb_pkg::scb_evt_t evt_i,
   input  wire logic              ext_cycle_i,    // external memory cycle in progress
   input  wire logic [7:0]        ext_addr_data_i,// low address or data during it
   input  wire logic [7:0]        port_zero_pin_i,
   input  wire logic [7:0]        port_one_pin_i,
   input  wire logic              ext_irq_a_pin_n_i,
   input  wire logic              ext_irq_b_pin_n_i,
   output logic [7:0]             rdata_o,
   output logic                   rvalid_o,
   output logic [7:0]             port_zero_out_o,
   output logic [7:0]             port_zero_oe_o,
   output logic                   ext_irq_a_pending_o,
   output logic                   ext_irq_b_pending_o,
   output logic                   timer_two_ext_input_o,
   output logic                   timer_two_reload_trigger_o,
   output logic                   adc_trigger_pulse_o,
   output scb_pkg::scb_ctl_t      ctl_o
);
   import scb_pkg::*;

   // ==========================================================
   // storage
   logic [7:0] port_zero_latch_ff;
   logic [7:0] stack_top_pointer_ff;
   logic [7:0] data_pointer_low_ff;
   logic [7:0] data_pointer_high_ff;
   logic [7:0] power_control_ff;
   logic [7:0] timer_control_ff;
   logic [7:0] chip_select_control_a_ff;
   logic [7:0] p0_meta_ff;
   logic [7:0] p0_sync_ff;
   logic [7:0] p1_meta_ff;
   logic [7:0] p1_sync_ff;
   logic       adc_prev_ff;
   logic       a_low;
   logic       a_fall;
   logic       b_low;
   logic       b_fall;

   // ==========================================================
   // access decode
   logic       hit;
   logic [7:0] byte_addr;
   logic [2:0] bit_sel;
   logic       byte_wr;
   logic       bit_wr;
   logic [7:0] nxt_wbyte;
   logic [7:0] cur_byte;
   logic       tc_wr;

   // bit address 80h-FFh maps to byte (addr & F8h), bit addr[2:0]
   assign byte_addr = req_i.bit_op ? {req_i.addr[7:3], 3'h0} : req_i.addr;
   assign bit_sel   = req_i.addr[2:0];
   // indirect or low-half accesses never reach the bank
   assign hit       = req_i.direct & req_i.addr[7];
   assign byte_wr   = hit & req_i.wr & ~req_i.bit_op;
   assign bit_wr    = hit & req_i.wr & req_i.bit_op & is_bit_addr(byte_addr);
   // a type bit written now governs pending in the same cycle, so level mode never lags
   assign tc_wr     = (byte_wr | bit_wr) && byte_addr == SCB_ADDR_TIMER_CTL;

   // bit addressable when the low hex digit is 0 or 8
   function automatic logic is_bit_addr(input logic [7:0] a);
      is_bit_addr = (a[2:0] == 3'h0);
   endfunction

   // read view of one address; missing bits and addresses read one
   function automatic logic [7:0] read_view(input logic [7:0] a);
      if (a == SCB_ADDR_PORT_ZERO)
         read_view = p0_sync_ff;
      else if (a == SCB_ADDR_STACK_TOP)
         read_view = stack_top_pointer_ff;
      else if (a == SCB_ADDR_DPTR_LOW)
         read_view = data_pointer_low_ff;
      else if (a == SCB_ADDR_DPTR_HIGH)
         read_view = data_pointer_high_ff;
      else if (a == SCB_ADDR_POWER)
         read_view = power_control_ff | SCB_PWR_RSVD_MASK;
      else if (a == SCB_ADDR_TIMER_CTL)
         read_view = timer_control_ff;
      else if (a == SCB_ADDR_PORT_ONE)
         read_view = p1_sync_ff;
      else if (a == SCB_ADDR_CS_CTL_A)
         read_view = chip_select_control_a_ff;
      else
         read_view = 8'hFF;
   endfunction

   // merged write byte: whole byte, or one bit patched into current value
   always_comb
   begin
      cur_byte  = read_view(byte_addr);
      nxt_wbyte = req_i.wdata;
      if (req_i.bit_op)
      begin
         nxt_wbyte          = cur_byte;
         nxt_wbyte[bit_sel] = req_i.wdata[0];
      end
   end

   // ==========================================================
   // read data, one cycle after the request
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         rdata_o  <= 8'hFF;
         rvalid_o <= 1'b0;
      end
      else
      begin
         rvalid_o <= hit & req_i.rd;
         if (hit & req_i.rd)
            rdata_o <= req_i.bit_op ? {7'h7F, cur_byte[bit_sel]} : cur_byte;
      end
   end

   // ==========================================================
   // port pin synchronisers
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         p0_meta_ff  <= 8'hFF;
         p0_sync_ff  <= 8'hFF;
         p1_meta_ff  <= SCB_RST_PORT_ONE;
         p1_sync_ff  <= SCB_RST_PORT_ONE;
         adc_prev_ff <= 1'b1;
      end
      else
      begin
         p0_meta_ff  <= port_zero_pin_i;
         p0_sync_ff  <= p0_meta_ff;
         p1_meta_ff  <= port_one_pin_i;
         p1_sync_ff  <= p1_meta_ff;
         adc_prev_ff <= p1_sync_ff[SCB_P1_ADC_START];
      end
   end

   // port one alternate inputs; pwm and analog pins live in their blocks
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         timer_two_ext_input_o      <= 1'b1;
         timer_two_reload_trigger_o <= 1'b1;
         adc_trigger_pulse_o        <= 1'b0;
      end
      else
      begin
         timer_two_ext_input_o      <= p1_sync_ff[SCB_P1_T2_INPUT];
         timer_two_reload_trigger_o <= p1_sync_ff[SCB_P1_T2_RELOAD];
         adc_trigger_pulse_o        <= p1_sync_ff[SCB_P1_ADC_START] & ~adc_prev_ff;
      end
   end

   // ==========================================================
   // port zero latch and pad drive
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         port_zero_latch_ff <= SCB_RST_PORT_ZERO;
      else if ((byte_wr | bit_wr) && byte_addr == SCB_ADDR_PORT_ZERO)
         port_zero_latch_ff <= nxt_wbyte;
   end

   // quasi-bidirectional: drive only zeros, pull-ups give ones; bus cycles drive all
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         port_zero_out_o <= 8'hFF;
         port_zero_oe_o  <= 8'h00;
      end
      else if (ext_cycle_i)
      begin
         port_zero_out_o <= ext_addr_data_i;
         port_zero_oe_o  <= 8'hFF;
      end
      else
      begin
         port_zero_out_o <= port_zero_latch_ff;
         port_zero_oe_o  <= ~port_zero_latch_ff;
      end
   end

   // ==========================================================
   // stack pointer, data pointer, chip-select control
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         stack_top_pointer_ff     <= SCB_RST_STACK_TOP;
         data_pointer_low_ff      <= SCB_RST_DPTR;
         data_pointer_high_ff     <= SCB_RST_DPTR;
         chip_select_control_a_ff <= SCB_RST_CS_CTL_A;
      end
      else if (byte_wr)
      begin
         if (byte_addr == SCB_ADDR_STACK_TOP)
            stack_top_pointer_ff <= nxt_wbyte;
         else if (byte_addr == SCB_ADDR_DPTR_LOW)
            data_pointer_low_ff <= nxt_wbyte;
         else if (byte_addr == SCB_ADDR_DPTR_HIGH)
            data_pointer_high_ff <= nxt_wbyte;
         else if (byte_addr == SCB_ADDR_CS_CTL_A)
            chip_select_control_a_ff <= nxt_wbyte;
      end
   end

   // ==========================================================
   // power control; mode bits drop when a wake event resumes the core
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         power_control_ff <= SCB_RST_POWER;
      else
      begin
         if (byte_wr && byte_addr == SCB_ADDR_POWER)
            power_control_ff <= nxt_wbyte & ~SCB_PWR_RSVD_MASK;
         if (evt_i.wake)
         begin
            power_control_ff[SCB_PWR_POWER_DOWN] <= 1'b0;
            power_control_ff[SCB_PWR_SLEEP_CPU]  <= 1'b0;
         end
      end
   end

   // ==========================================================
   // external interrupt detectors
   scb_irq_detect u_irq_a
   (
      .clk_i       (clk_i),
      .arst_n_i    (arst_n_i),
      .pin_n_i     (ext_irq_a_pin_n_i),
      .type_edge_i (timer_control_ff[SCB_TC_A_TYPE]),
      .level_low_o (a_low),
      .fall_o      (a_fall)
   );

   scb_irq_detect u_irq_b
   (
      .clk_i       (clk_i),
      .arst_n_i    (arst_n_i),
      .pin_n_i     (ext_irq_b_pin_n_i),
      .type_edge_i (timer_control_ff[SCB_TC_B_TYPE]),
      .level_low_o (b_low),
      .fall_o      (b_fall)
   );

   // ==========================================================
   // timer control; hardware set wins over any clear in the same cycle
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         timer_control_ff <= SCB_RST_TIMER_CTL;
      else
      begin
         if (tc_wr)
            timer_control_ff <= nxt_wbyte;
         // isr entry clears, applied before sets so sets override
         if (evt_i.t1_isr_enter)
            timer_control_ff[SCB_TC_T1_OVF] <= 1'b0;
         if (evt_i.t0_isr_enter)
            timer_control_ff[SCB_TC_T0_OVF] <= 1'b0;
         if (evt_i.b_isr_enter & timer_control_ff[SCB_TC_B_TYPE])
            timer_control_ff[SCB_TC_B_PEND] <= 1'b0;
         if (evt_i.a_isr_enter & timer_control_ff[SCB_TC_A_TYPE])
            timer_control_ff[SCB_TC_A_PEND] <= 1'b0;
         if (evt_i.t1_overflow)
            timer_control_ff[SCB_TC_T1_OVF] <= 1'b1;
         if (evt_i.t0_overflow)
            timer_control_ff[SCB_TC_T0_OVF] <= 1'b1;
         // level mode follows the pin, edge mode latches a fall
         if (!(tc_wr ? nxt_wbyte[SCB_TC_B_TYPE] : timer_control_ff[SCB_TC_B_TYPE]))
            timer_control_ff[SCB_TC_B_PEND] <= b_low;
         else if (b_fall)
            timer_control_ff[SCB_TC_B_PEND] <= 1'b1;
         if (!(tc_wr ? nxt_wbyte[SCB_TC_A_TYPE] : timer_control_ff[SCB_TC_A_TYPE]))
            timer_control_ff[SCB_TC_A_PEND] <= a_low;
         else if (a_fall)
            timer_control_ff[SCB_TC_A_PEND] <= 1'b1;
      end
   end

   // ==========================================================
   // registered control outputs
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ctl_o               <= '0;
         ctl_o.cpu_clk_en    <= 1'b1;
         ctl_o.periph_clk_en <= 1'b1;
         ctl_o.stack_top     <= SCB_RST_STACK_TOP;
         ext_irq_a_pending_o <= 1'b0;
         ext_irq_b_pending_o <= 1'b0;
      end
      else
      begin
         ctl_o.baud_double        <= power_control_ff[SCB_PWR_BAUD_DOUBLE];
         ctl_o.frame_error_enable <= power_control_ff[SCB_PWR_FRAME_ERR_EN];
         ctl_o.timer_one_run      <= timer_control_ff[SCB_TC_T1_RUN];
         ctl_o.timer_zero_run     <= timer_control_ff[SCB_TC_T0_RUN];
         // either mode stops the cpu; only power-down stops peripherals
         ctl_o.cpu_clk_en    <= ~(power_control_ff[SCB_PWR_POWER_DOWN]
                                | power_control_ff[SCB_PWR_SLEEP_CPU]);
         ctl_o.periph_clk_en <= ~power_control_ff[SCB_PWR_POWER_DOWN];
         ctl_o.data_pointer  <= {data_pointer_high_ff, data_pointer_low_ff};
         ctl_o.stack_top     <= stack_top_pointer_ff;
         ctl_o.cs_ctl_a      <= chip_select_control_a_ff;
         ext_irq_a_pending_o <= timer_control_ff[SCB_TC_A_PEND];
         ext_irq_b_pending_o <= timer_control_ff[SCB_TC_B_PEND];
      end
   end
endmodule // scb_sfr_bank

// *** verif/scb_sfr_bank_sva.sv ***
// checker: port-level properties of the sfr bank
`timescale 1ns/10ps
module scb_sfr_bank_sva
(
   input  wire logic              clk_i,
   input  wire logic              arst_n_i,
   input  wire scb_pkg::scb_req_t req_i,
   input  wire scb_pkg::scb_evt_t evt_i,
   input  wire logic              ext_cycle_i,
   input  wire logic [7:0]        ext_addr_data_i,
   input  wire logic [7:0]        port_one_pin_i,
   input  wire logic [7:0]        rdata_o,
   input  wire logic              rvalid_o,
   input  wire logic [7:0]        port_zero_out_o,
   input  wire logic [7:0]        port_zero_oe_o,
   input  wire logic              adc_trigger_pulse_o,
   input  wire scb_pkg::scb_ctl_t ctl_o
);
   import scb_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   // accepted accesses and plain byte writes
   logic hit;
   logic bw;
   assign hit = req_i.direct && req_i.addr[7];
   assign bw  = hit && req_i.wr && !req_i.bit_op;
   // ==========
   // access decode
   chk_read_answer: assert property (hit && req_i.rd |=> rvalid_o)
      else $error("accepted read got no answer");
   chk_refuse_other: assert property (!(hit && req_i.rd) |=> !rvalid_o)
      else $error("answer without an accepted read");
   chk_bit_read: assert property (hit && req_i.rd && req_i.bit_op |=> rdata_o[7:1] == 7'h7F)
      else $error("bit read upper bits not ones");
   // ==========
   // register mirrors, two cycles after the write
   chk_stack_mirror: assert property (bw && req_i.addr == SCB_ADDR_STACK_TOP
      |-> ##2 ctl_o.stack_top == $past(req_i.wdata, 2))
      else $error("stack top mirror wrong");
   chk_dptr_high: assert property (bw && req_i.addr == SCB_ADDR_DPTR_HIGH
      |=> ##1 ctl_o.data_pointer[15:8] == $past(req_i.wdata, 2))
      else $error("data pointer high wrong");
   chk_serial_bits: assert property (bw && req_i.addr == SCB_ADDR_POWER |-> ##2
      {ctl_o.baud_double, ctl_o.frame_error_enable} == $past(req_i.wdata[7:6], 2))
      else $error("serial control bits wrong");
   chk_timer_run: assert property (bw && req_i.addr == SCB_ADDR_TIMER_CTL |-> ##2
      {ctl_o.timer_one_run, ctl_o.timer_zero_run} == {$past(req_i.wdata[6], 2),
      $past(req_i.wdata[4], 2)})
      else $error("timer run bits wrong");
   // ==========
   // power modes; a wake in the next cycle would legally cut them short
   chk_idle_clocks: assert property (bw && req_i.addr == SCB_ADDR_POWER
      && req_i.wdata[1:0] == 2'b01 ##1 !evt_i.wake
      |=> !ctl_o.cpu_clk_en && ctl_o.periph_clk_en)
      else $error("idle clock gating wrong");
   chk_pdown_clocks: assert property (bw && req_i.addr == SCB_ADDR_POWER
      && req_i.wdata[1] ##1 !evt_i.wake
      |=> !ctl_o.cpu_clk_en && !ctl_o.periph_clk_en)
      else $error("power down clock gating wrong");
   // ==========
   // pins
   chk_ext_bus: assert property (ext_cycle_i
      |=> port_zero_oe_o == 8'hFF && port_zero_out_o == $past(ext_addr_data_i))
      else $error("external bus not on port zero");
   chk_adc_start: assert property ($rose(port_one_pin_i[2]) |-> ##[1:4] adc_trigger_pulse_o)
      else $error("adc start pulse missing");
   cov_bit_write: cover property (hit && req_i.wr && req_i.bit_op);
   cov_overflow: cover property (evt_i.t1_overflow);
   cov_adc: cover property (adc_trigger_pulse_o);
endmodule // scb_sfr_bank_sva

bind scb_sfr_bank scb_sfr_bank_sva u_sva (.clk_i, .arst_n_i, .req_i, .evt_i, .ext_cycle_i,
   .ext_addr_data_i, .port_one_pin_i, .rdata_o, .rvalid_o, .port_zero_out_o, .port_zero_oe_o,
   .adc_trigger_pulse_o, .ctl_o);

// *** verif/sfr_core_control_bank_tb_top.sv ***
// testbench: self-checking stimulus for the sfr bank
`timescale 1ns/10ps
module sfr_core_control_bank_tb_top;
   import scb_pkg::*;
   logic       clk_i, arst_n_i, ext_cycle, irq_a_n, irq_b_n, rvalid, v;
   logic       pend_a, pend_b, t2_in, t2_rl, adc_pulse;
   logic [7:0] ext_ad, p0_pin, p1_pin, rdata, p0_out, p0_oe, d, got, a;
   scb_req_t   req;
   scb_evt_t   evt;
   scb_ctl_t   ctl;
   int         bad_count, tests_run, cyc;

   scb_sfr_bank u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req), .evt_i(evt),
      .ext_cycle_i(ext_cycle), .ext_addr_data_i(ext_ad), .port_zero_pin_i(p0_pin),
      .port_one_pin_i(p1_pin), .ext_irq_a_pin_n_i(irq_a_n), .ext_irq_b_pin_n_i(irq_b_n),
      .rdata_o(rdata), .rvalid_o(rvalid), .port_zero_out_o(p0_out), .port_zero_oe_o(p0_oe),
      .ext_irq_a_pending_o(pend_a), .ext_irq_b_pending_o(pend_b), .timer_two_ext_input_o(t2_in),
      .timer_two_reload_trigger_o(t2_rl), .adc_trigger_pulse_o(adc_pulse), .ctl_o(ctl));

   // ==========
   // clock and hang guard; the whole run needs well under 1000 cycles
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         bad_count++;
         finish_test();
      end
   end

   // ==========
   // compares and bus tasks
   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] seen);
      tests_run++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic chk1(input string what, input logic exp, input logic seen);
      chk8(what, {7'h00, exp}, {7'h00, seen});
   endtask
   // request stays up until the caller drives the next one or idles
   task automatic acc(input logic r, w, b, dir, input logic [7:0] ad, wd);
      req = '{rd: r, wr: w, bit_op: b, direct: dir, addr: ad, wdata: wd};
      @(negedge clk_i);
      got = rdata;
      v = rvalid;
   endtask
   task automatic rd8(input logic [7:0] ad, input logic [7:0] exp, input string what);
      acc(1'b1, 1'b0, 1'b0, 1'b1, ad, 8'h00);
      chk1(what, 1'b1, v);
      chk8(what, exp, got);
   endtask
   task automatic idle(input int n);
      req = '0;
      repeat (n) @(negedge clk_i);
   endtask
   task automatic pulse(input scb_evt_t e);
      req = '0;
      evt = e;
      @(negedge clk_i);
      evt = '0;
      @(negedge clk_i);
   endtask
   // readback of a byte write; level-mode pending bits follow the idle-high pins
   function automatic logic [7:0] exp_rd(input logic [7:0] ad, input logic [7:0] wd);
      exp_rd = wd;
      if (ad == SCB_ADDR_POWER)
         exp_rd = wd | SCB_PWR_RSVD_MASK;
      if (ad == SCB_ADDR_TIMER_CTL)
         exp_rd = {wd[7:4], wd[3] & wd[2], wd[2], wd[1] & wd[0], wd[0]};
   endfunction
   task automatic finish_test();
      $display("counts: %0d compares, %0d mismatches", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ==========
   // main sequence
   initial
   begin
      logic [7:0] tbl [6];
      logic [6:0] evts [4];
      logic [7:0] flags [4];
      tbl = '{8'h81, 8'h82, 8'h83, 8'h92, 8'h87, 8'h88};
      evts = '{7'h40, 7'h10, 7'h20, 7'h08};
      flags = '{8'h80, 8'h00, 8'h20, 8'h00};
      void'($urandom(32'hF8912762));
      arst_n_i = 1'b0;
      req = '0;
      evt = '0;
      ext_cycle = 1'b0;
      ext_ad = 8'h00;
      p0_pin = $urandom;
      p1_pin = 8'h00;
      irq_a_n = 1'b1;
      irq_b_n = 1'b1;
      repeat (6) @(negedge clk_i);
      arst_n_i = 1'b1;
      // port pins need two edges through the synchroniser before they read back
      idle(2);
      rd8(SCB_ADDR_PORT_ZERO, p0_pin, "port zero pins");
      rd8(SCB_ADDR_STACK_TOP, SCB_RST_STACK_TOP, "stack reset");
      rd8(SCB_ADDR_DPTR_LOW, 8'h00, "dptr low reset");
      rd8(SCB_ADDR_DPTR_HIGH, 8'h00, "dptr high reset");
      rd8(SCB_ADDR_POWER, SCB_PWR_RSVD_MASK, "power reset");
      rd8(SCB_ADDR_TIMER_CTL, 8'h00, "timer reset");
      rd8(SCB_ADDR_CS_CTL_A, 8'h00, "cs reset");
      rd8(8'h84, 8'hFF, "unmapped");
      chk8("port zero oe reset", 8'h00, p0_oe);
      $display("test reset_map done");
      // refused accesses leave the stack pointer alone
      acc(1'b1, 1'b0, 1'b0, 1'b0, SCB_ADDR_STACK_TOP, 8'h00);
      chk1("indirect read valid", 1'b0, v);
      acc(1'b1, 1'b0, 1'b0, 1'b1, 8'h7F, 8'h00);
      chk1("low read valid", 1'b0, v);
      acc(1'b0, 1'b1, 1'b0, 1'b0, SCB_ADDR_STACK_TOP, 8'h55);
      rd8(SCB_ADDR_STACK_TOP, SCB_RST_STACK_TOP, "stack after refused");
      $display("test refusals done");
      // random back-to-back writes and readbacks; sleep bits kept clear here
      for (int i = 0; i < 30; i++)
      begin
         a = tbl[$urandom % 6];
         d = $urandom;
         p0_pin = $urandom;
         if (a == SCB_ADDR_POWER)
            d[1:0] = 2'b00;
         acc(1'b0, 1'b1, 1'b0, 1'b1, a, d);
         rd8(a, exp_rd(a, d), "random readback");
      end
      // bit writes to port zero merge into the pin view, so park the pins high
      p0_pin = 8'hFF;
      acc(1'b0, 1'b1, 1'b0, 1'b1, SCB_ADDR_CS_CTL_A, 8'h5A);
      acc(1'b0, 1'b1, 1'b0, 1'b1, SCB_ADDR_DPTR_LOW, 8'hA5);
      acc(1'b0, 1'b1, 1'b0, 1'b1, SCB_ADDR_DPTR_HIGH, 8'h3C);
      idle(1);
      chk8("dptr low", 8'hA5, ctl.data_pointer[7:0]);
      chk8("dptr high", 8'h3C, ctl.data_pointer[15:8]);
      chk8("cs ctl", 8'h5A, ctl.cs_ctl_a);
      $display("test random_regs done");
      // idle then power down, each left by a wake pulse
      for (int m = 1; m < 3; m++)
      begin
         acc(1'b0, 1'b1, 1'b0, 1'b1, SCB_ADDR_POWER, m[7:0]);
         idle(1);
         chk1("cpu clock", 1'b0, ctl.cpu_clk_en);
         chk1("periph clock", m == 1, ctl.periph_clk_en);
         pulse(7'h01);
         chk1("cpu clock back", 1'b1, ctl.cpu_clk_en);
         rd8(SCB_ADDR_POWER, SCB_PWR_RSVD_MASK, "power after wake");
      end
      $display("test power done");
      // overflow flags set by events, cleared on service entry
      acc(1'b0, 1'b1, 1'b0, 1'b1, SCB_ADDR_TIMER_CTL, 8'h00);
      for (int k = 0; k < 4; k++)
      begin
         pulse(evts[k]);
         rd8(SCB_ADDR_TIMER_CTL, flags[k], "overflow flag");
      end
      // bit access: set a run bit, test it, clear a port zero latch bit
      acc(1'b0, 1'b1, 1'b1, 1'b1, 8'h8E, 8'h01);
      acc(1'b1, 1'b0, 1'b1, 1'b1, 8'h8E, 8'h00);
      chk8("bit read", 8'hFF, got);
      rd8(SCB_ADDR_TIMER_CTL, 8'h40, "after bit set");
      acc(1'b0, 1'b1, 1'b1, 1'b1, 8'h83, 8'h00);
      idle(2);
      chk8("port zero drive", 8'h08, p0_oe);
      ext_ad = $urandom;
      ext_cycle = 1'b1;
      idle(2);
      chk8("ext bus data", ext_ad, p0_out);
      ext_cycle = 1'b0;
      $display("test flags_bits done");
      // pin a edge-triggered, pin b level-triggered
      acc(1'b0, 1'b1, 1'b0, 1'b1, SCB_ADDR_TIMER_CTL, 8'h01);
      irq_a_n = 1'b0;
      irq_b_n = 1'b0;
      idle(6);
      chk1("edge pending", 1'b1, pend_a);
      chk1("level pending", 1'b1, pend_b);
      irq_a_n = 1'b1;
      irq_b_n = 1'b1;
      idle(6);
      chk1("edge held", 1'b1, pend_a);
      chk1("level follows pin", 1'b0, pend_b);
      pulse(7'h02);
      idle(2);
      chk1("edge isr clear", 1'b0, pend_a);
      $display("test ext_irq done");
      // random port one pins; adc start pulses checked by property
      for (int i = 0; i < 8; i++)
      begin
         p1_pin = $urandom;
         idle(4);
         chk1("t2 input", p1_pin[0], t2_in);
         chk1("t2 reload", p1_pin[1], t2_rl);
         rd8(SCB_ADDR_PORT_ONE, p1_pin, "port one pins");
      end
      idle(1);
      $display("test port_one done");
      finish_test();
   end
endmodule // sfr_core_control_bank_tb_top
